// ---- ir_timer_common_control.sv ----
// Common control of the short and long IR timers with demodulator edge capture
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "timer_pair_map.svh"

// Functional notes
// - Long timer output starts at its initial level
// - Short timer output starts at its initial level
// - Falling flag reads one after falling edge
// - Writing one clears falling flag, zero ignored
// - Rising edge sets flag; write one clears
// - Submode: normal, ping-pong, long forced low/high
// - Demod glitch filter: none, 4, 8 cycles
// - Edge field: falling, rising, both, reserved
// - Pin select drives combined output on port pin
// - Pin select picks demodulator input pin
// - Edge code 01 detects rising edges only
// - Logic field combines outputs: AND/OR/NOR/NAND
// - Idle timer output holds opposite initial level
module ir_timer_common_control
    import timer_pair_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [31:0] araddr,
    input  wire logic [2:0]  arprot,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    input  wire logic        short_timer_enable,
    input  wire logic        short_timer_toggle,
    input  wire logic        long_timer_enable,
    input  wire logic        long_timer_toggle,
    input  wire logic        port3_bit6_port_data,
    input  wire logic        port3_bit1_pin,
    input  wire logic        port2_bit0_pin,
    output logic             short_timer_output,
    output logic             long_timer_output,
    output logic             port3_bit6_pin,
    output logic             irq
);

    core_state_t s_q;
    core_state_t s_d;
    logic        filt_out;
    logic        demod_in;
    logic        rise_evt;
    logic        fall_evt;
    logic        comb_out;
    logic        wr_do;
    logic        wr_ctrl;
    logic        wr_status;
    logic        wr_mask;
    logic        wr_hit;
    logic        rd_hit;
    logic [31:0] rd_word;
    logic        rise_set;
    logic        fall_set;
    logic        rise_clr;
    logic        fall_clr;
    logic [1:0]  filt_len;

    // Word decode; protection bits are accepted but do not gate access
    function automatic logic word_is(input logic [31:0] addr, input logic [7:0] idx);
        word_is = (addr[31:10] == 22'h0) && (addr[9:2] == idx);
    endfunction

    function automatic logic combine(input logic [1:0] sel, input logic a, input logic b);
        logic r;
        r = 1'b0;
        unique case (sel)
            COMB_AND:  r = a & b;
            COMB_OR:   r = a | b;
            COMB_NOR:  r = ~(a | b);
            COMB_NAND: r = ~(a & b);
        endcase
        combine = r;
    endfunction

    // Demodulator input choice and glitch filter; filter is bypassed in transmit
    assign demod_in = s_q.ctrl.pin_sel ? s_q.p20_sync : s_q.p31_sync;
    assign filt_len = s_q.ctrl.mode ? s_q.ctrl.sub_filt : FILT_NONE;

    glitch_filter u_filter (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .ce           (ce),
        .raw_in       (demod_in),
        .filter_len   (filt_len),
        .filtered_out (filt_out)
    );

    // Edge detection on the filtered input, gated by the edge field
    assign rise_evt = filt_out & ~s_q.filt_prev;
    assign fall_evt = ~filt_out & s_q.filt_prev;
    assign rise_set = s_q.ctrl.mode && rise_evt &&
        (s_q.ctrl.logic_edge == EDGE_RISE || s_q.ctrl.logic_edge == EDGE_BOTH);
    assign fall_set = s_q.ctrl.mode && fall_evt &&
        (s_q.ctrl.logic_edge == EDGE_FALL || s_q.ctrl.logic_edge == EDGE_BOTH);

    // Combined transmit output from the two registered timer outputs
    assign comb_out = combine(s_q.ctrl.logic_edge, s_q.short_out, s_q.long_out);

    // Write decode; a write completes once both address and data are held
    assign wr_do     = s_q.aw_have && s_q.w_have && !s_q.bvalid;
    assign wr_ctrl   = wr_do && s_q.w_strb[0] && word_is(s_q.aw_addr, `CTRL_IDX);
    assign wr_status = wr_do && s_q.w_strb[0] && word_is(s_q.aw_addr, `STATUS_IDX);
    assign wr_mask   = wr_do && s_q.w_strb[0] && word_is(s_q.aw_addr, `MASK_IDX);
    assign wr_hit    = word_is(s_q.aw_addr, `CTRL_IDX) || word_is(s_q.aw_addr, `STATUS_IDX)
                       || word_is(s_q.aw_addr, `MASK_IDX);

    // Flag clears only act in demodulation mode, where the low bits are flags
    assign rise_clr = wr_ctrl && s_q.ctrl.mode && s_q.w_data[1];
    assign fall_clr = wr_ctrl && s_q.ctrl.mode && s_q.w_data[0];

    // Read data mux; the low control bits show flags in demodulation mode
    always_comb
    begin
        rd_word = 32'h0;
        rd_hit  = 1'b1;
        if (word_is(araddr, `CTRL_IDX))
        begin
            rd_word[7:2] = {s_q.ctrl.mode, s_q.ctrl.pin_sel,
                            s_q.ctrl.logic_edge, s_q.ctrl.sub_filt};
            rd_word[1]   = s_q.ctrl.mode ? s_q.flags.rise : s_q.ctrl.short_init;
            rd_word[0]   = s_q.ctrl.mode ? s_q.flags.fall : s_q.ctrl.long_init;
        end
        else if (word_is(araddr, `STATUS_IDX))
            rd_word[1:0] = s_q.irq_status;
        else if (word_is(araddr, `MASK_IDX))
            rd_word[1:0] = s_q.irq_mask;
        else
            rd_hit = 1'b0;
    end

    // Next state of the whole block
    always_comb
    begin
        s_d = s_q;

        // Write address and data channels are taken independently
        if (awvalid && s_q.awready)
        begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = awaddr;
        end
        if (wvalid && s_q.wready)
        begin
            s_d.w_have = 1'b1;
            s_d.w_data = wdata;
            s_d.w_strb = wstrb;
        end
        if (s_q.bvalid && bready)
            s_d.bvalid = 1'b0;
        if (wr_do)
        begin
            s_d.aw_have = 1'b0;
            s_d.w_have  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end

        // Control register; in demodulation mode the initial bits are kept
        if (wr_ctrl)
        begin
            s_d.ctrl.mode       = s_q.w_data[7];
            s_d.ctrl.pin_sel    = s_q.w_data[6];
            s_d.ctrl.logic_edge = s_q.w_data[5:4];
            s_d.ctrl.sub_filt   = s_q.w_data[3:2];
            if (!s_q.ctrl.mode)
            begin
                s_d.ctrl.short_init = s_q.w_data[1];
                s_d.ctrl.long_init  = s_q.w_data[0];
            end
        end
        if (wr_mask)
            s_d.irq_mask = s_q.w_data[1:0];

        // Sticky flags: a set in the clearing cycle wins
        s_d.flags.rise = rise_set | (s_q.flags.rise & ~rise_clr);
        s_d.flags.fall = fall_set | (s_q.flags.fall & ~fall_clr);
        s_d.irq_status.rise = rise_set |
            (s_q.irq_status.rise & ~(wr_status & s_q.w_data[1]));
        s_d.irq_status.fall = fall_set |
            (s_q.irq_status.fall & ~(wr_status & s_q.w_data[0]));
        s_d.irq = |(s_d.irq_status & s_d.irq_mask);

        // Read channel: data is ready the cycle after the address is taken
        if (s_q.rvalid && rready)
            s_d.rvalid = 1'b0;
        if (arvalid && s_q.arready)
        begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = rd_word;
            s_d.rresp  = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end

        // Ready only while nothing is held and no answer waits
        s_d.awready = !s_d.aw_have && !s_d.bvalid;
        s_d.wready  = !s_d.w_have && !s_d.bvalid;
        s_d.arready = !s_d.rvalid;

        // Two-stage synchronisers on the input pins
        s_d.p31_meta  = port3_bit1_pin;
        s_d.p31_sync  = s_q.p31_meta;
        s_d.p20_meta  = port2_bit0_pin;
        s_d.p20_sync  = s_q.p20_meta;
        s_d.filt_prev = filt_out;

        // Short timer output: idle opposite, initial level at start, then toggles
        s_d.short_en_prev = short_timer_enable;
        if (!short_timer_enable)
            s_d.short_out = ~s_q.ctrl.short_init;
        else if (!s_q.short_en_prev)
            s_d.short_out = s_q.ctrl.short_init;
        else if (short_timer_toggle)
            s_d.short_out = ~s_q.short_out;

        // Long timer output; forced codes override counting in transmit mode
        s_d.long_en_prev = long_timer_enable;
        if (!s_q.ctrl.mode && s_q.ctrl.sub_filt == SUB_FORCE_LOW)
            s_d.long_out = 1'b0;
        else if (!s_q.ctrl.mode && s_q.ctrl.sub_filt == SUB_FORCE_HIGH)
            s_d.long_out = 1'b1;
        else if (!long_timer_enable)
            s_d.long_out = ~s_q.ctrl.long_init;
        else if (!s_q.long_en_prev)
            s_d.long_out = s_q.ctrl.long_init;
        else if (long_timer_toggle)
            s_d.long_out = ~s_q.long_out;

        // Port pin carries the combined output only when selected in transmit
        s_d.pin_out = (!s_q.ctrl.mode && s_q.ctrl.pin_sel) ? comb_out
                                                           : port3_bit6_port_data;
    end

    // State register; idle timer outputs reset high, the opposite of level 0
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q           <= '0;
            s_q.ctrl      <= `CTRL_RESET;
            s_q.flags     <= `FLAGS_RESET;
            s_q.short_out <= 1'b1;
            s_q.long_out  <= 1'b1;
        end
        else if (ce)
        begin
            s_q <= s_d;
        end
    end

    // Every output comes from the state register
    assign awready            = s_q.awready;
    assign wready             = s_q.wready;
    assign bvalid             = s_q.bvalid;
    assign bresp              = s_q.bresp;
    assign arready            = s_q.arready;
    assign rvalid             = s_q.rvalid;
    assign rdata              = s_q.rdata;
    assign rresp              = s_q.rresp;
    assign short_timer_output = s_q.short_out;
    assign long_timer_output  = s_q.long_out;
    assign port3_bit6_pin     = s_q.pin_out;
    assign irq                = s_q.irq;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_short_idle_level: assert property (
        ce && !short_timer_enable |=> short_timer_output == !$past(s_q.ctrl.short_init))
        else $error("idle short output not opposite of initial level");

    a_short_start_level: assert property (
        ce && short_timer_enable && !s_q.short_en_prev
        |=> short_timer_output == $past(s_q.ctrl.short_init))
        else $error("short output did not start at initial level");

    a_long_start_level: assert property (
        ce && long_timer_enable && !s_q.long_en_prev && !s_q.ctrl.sub_filt[1]
        |=> long_timer_output == $past(s_q.ctrl.long_init))
        else $error("long output did not start at initial level");

    a_long_forced_level: assert property (
        ce && !s_q.ctrl.mode && s_q.ctrl.sub_filt[1]
        |=> long_timer_output == $past(s_q.ctrl.sub_filt[0]))
        else $error("long output not forced by submode");

    a_rise_flag_set: assert property (
        ce && s_q.ctrl.mode && s_q.ctrl.logic_edge == EDGE_RISE && rise_evt
        |=> s_q.flags.rise && !$rose(s_q.flags.fall))
        else $error("rising edge did not set only the rising flag");

    a_fall_flag_set: assert property (
        ce && s_q.ctrl.mode && s_q.ctrl.logic_edge == EDGE_FALL && fall_evt
        |=> s_q.flags.fall ##1 (rdata[0] || !rvalid || !$past(arvalid)))
        else $error("falling edge did not set the falling flag");

    a_fall_flag_clear: assert property (
        ce && s_q.flags.fall && fall_clr && !fall_set |=> !s_q.flags.fall)
        else $error("write of one did not clear the falling flag");

    a_edge_reserved: assert property (
        ce && s_q.ctrl.logic_edge == EDGE_RSVD |=> !$rose(s_q.flags.rise)
        && !$rose(s_q.flags.fall))
        else $error("reserved edge code set a flag");

    a_mode_no_flags: assert property (
        ce && !s_q.ctrl.mode |=> !$rose(s_q.flags.rise) && !$rose(s_q.flags.fall))
        else $error("edge flag set in transmit mode");

    a_pin_combined: assert property (
        ce && !s_q.ctrl.mode && s_q.ctrl.pin_sel |=> port3_bit6_pin == $past(comb_out))
        else $error("port pin does not carry the combined output");

    // An unmasked edge raises the interrupt at the next edge unless a mask write vetoes it
    a_irq_level: assert property (
        ce && !wr_mask && ((rise_set && s_q.irq_mask.rise) || (fall_set && s_q.irq_mask.fall))
        |=> irq)
        else $error("interrupt not raised by an unmasked edge event");

    a_write_answer: assert property (
        ce && awvalid && awready && wvalid && wready ##1 ce |=> bvalid)
        else $error("write not answered two edges after address and data");

    c_rise_capture: cover property (s_q.ctrl.mode && $rose(s_q.flags.rise));
    c_pingpong_pin: cover property (s_q.ctrl.sub_filt == SUB_PING_PONG && s_q.ctrl.pin_sel
                                    && $changed(port3_bit6_pin));
    c_flag_cleared: cover property (s_q.ctrl.mode && $fell(s_q.flags.fall));

endmodule

// ---- timer_pair_map.svh ----
// Register indices, reset values and timing counts of the timer pair control block
`ifndef TIMER_PAIR_MAP_SVH
`define TIMER_PAIR_MAP_SVH

// Register indices; byte address is four times the index
`define CTRL_IDX       8'h01
`define STATUS_IDX     8'h02
`define MASK_IDX       8'h03

// Reset values
`define CTRL_RESET     8'h00
`define FLAGS_RESET    2'h0

// Glitch filter lengths in system clock cycles
`define FILT_SHORT_CYC 4'h4
`define FILT_LONG_CYC  4'h8

// AXI4-Lite responses
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// ---- timer_pair_pkg.sv ----
// Types shared by the timer pair control block and its glitch filter
package timer_pair_pkg;

    typedef enum logic [1:0] {
        COMB_AND  = 2'h0,
        COMB_OR   = 2'h1,
        COMB_NOR  = 2'h2,
        COMB_NAND = 2'h3
    } combine_t;

    typedef enum logic [1:0] {
        EDGE_FALL = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_BOTH = 2'h2,
        EDGE_RSVD = 2'h3
    } edge_sel_t;

    typedef enum logic [1:0] {
        SUB_NORMAL     = 2'h0,
        SUB_PING_PONG  = 2'h1,
        SUB_FORCE_LOW  = 2'h2,
        SUB_FORCE_HIGH = 2'h3
    } submode_t;

    typedef enum logic [1:0] {
        FILT_NONE  = 2'h0,
        FILT_SHORT = 2'h1,
        FILT_LONG  = 2'h2,
        FILT_RSVD  = 2'h3
    } filter_len_t;

    // Common control register, bit 7 down to bit 0
    typedef struct packed {
        logic       mode;
        logic       pin_sel;
        logic [1:0] logic_edge;
        logic [1:0] sub_filt;
        logic       short_init;
        logic       long_init;
    } ctrl_reg_t;

    // Edge events, same layout as status and mask
    typedef struct packed {
        logic rise;
        logic fall;
    } edge_flags_t;

    typedef struct packed {
        logic       out;
        logic [3:0] cnt;
    } filter_state_t;

    typedef struct packed {
        logic        aw_have;
        logic [31:0] aw_addr;
        logic        w_have;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        ctrl_reg_t   ctrl;
        edge_flags_t flags;
        edge_flags_t irq_status;
        edge_flags_t irq_mask;
        logic        irq;
        logic        p31_meta;
        logic        p31_sync;
        logic        p20_meta;
        logic        p20_sync;
        logic        filt_prev;
        logic        short_en_prev;
        logic        long_en_prev;
        logic        short_out;
        logic        long_out;
        logic        pin_out;
    } core_state_t;

endpackage

// ---- glitch_filter.sv ----
// Glitch filter that passes a level only after it has been stable long enough
`timescale 1ns/1ps
`include "timer_pair_map.svh"

module glitch_filter
    import timer_pair_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic        raw_in,
    input  wire logic [1:0]  filter_len,
    output logic             filtered_out
);

    filter_state_t s_q;
    filter_state_t s_d;
    logic [3:0]    thresh;

    // Reserved code takes the longer filter rather than none
    always_comb
    begin
        unique case (filter_len)
            FILT_SHORT: thresh = `FILT_SHORT_CYC;
            default:    thresh = `FILT_LONG_CYC;
        endcase
    end

    // Output follows raw_in directly for FILT_NONE, otherwise only after raw_in differs for thresh cycles in a row
    always_comb
    begin
        s_d = s_q;
        if (filter_len == FILT_NONE)
        begin
            s_d.out = raw_in;
            s_d.cnt = 4'h0;
        end
        else if (raw_in == s_q.out)
        begin
            s_d.cnt = 4'h0;
        end
        else if (s_q.cnt == thresh - 4'h1)
        begin
            s_d.out = raw_in;
            s_d.cnt = 4'h0;
        end
        else
        begin
            s_d.cnt = s_q.cnt + 4'h1;
        end
    end

    // State register, frozen while ce is low
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_q <= '0;
        else if (ce)
            s_q <= s_d;
    end

    assign filtered_out = s_q.out;

    a_filter_reject: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && filter_len != FILT_NONE && raw_in != s_q.out && s_q.cnt < thresh - 4'h1
        |=> s_q.out == $past(s_q.out))
        else $error("filter passed a pulse shorter than its length");

    c_filter_pass: cover property (@(posedge aclk) disable iff (!aresetn)
        filter_len == FILT_SHORT && $changed(s_q.out));

endmodule

// ---- ir_link_model.sv ----
// Model of the infrared receiver that drives the two demodulator input pins
`timescale 1ns/1ps
module ir_link_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       fire,
    input  wire logic       use_alt,
    input  wire logic [3:0] width,
    output logic            port3_bit1_pin,
    output logic            port2_bit0_pin
);
    logic [3:0] left_q;
    logic       alt_q;

    // Both lines idle high; a burst pulls the chosen line low for width cycles
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            left_q <= 4'h0;
        else if (fire)
            left_q <= width;
        else if (left_q != 4'h0)
            left_q <= left_q - 4'h1;
        if (fire)
            alt_q <= use_alt;
    end

    // The other line stays idle, so a wrong input selection sees no edge
    assign port3_bit1_pin = !(left_q != 4'h0 && !alt_q);
    assign port2_bit0_pin = !(left_q != 4'h0 && alt_q);
endmodule

// ---- ir_timer_common_control_tb_top.sv ----
// Self-checking bench for the timer pair common control block
`timescale 1ns/1ps
`include "timer_pair_map.svh"
module ir_timer_common_control_tb_top
    import timer_pair_pkg::*;
;
    logic        aclk = 1'h0;
    logic        aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, irq, fire, alt;
    logic        short_timer_enable, short_timer_toggle, long_timer_enable;
    logic        long_timer_toggle, port3_bit6_port_data, port3_bit1_pin;
    logic        port2_bit0_pin, short_timer_output, long_timer_output;
    logic        port3_bit6_pin, el;
    logic [31:0] awaddr, wdata, araddr, rdata, rdv, seed;
    logic [3:0]  wstrb, width;
    logic [2:0]  awprot, arprot;
    logic [1:0]  bresp, rresp, resp, ini, ef, mk;
    logic [15:0] c;
    // Last entry uses the reserved filter code, which behaves as the long filter
    logic [15:0] dcase [10] = '{16'h0086, 16'h1086, 16'h2386, 16'h3086, 16'h2106,
                                16'h2402, 16'h2487, 16'h2B06, 16'h2B8C, 16'h2C06};
    int          failures = 0;
    int          num_checks = 0;
    int          cyc = 0;

    always #12.5 aclk = ~aclk;

    ir_timer_common_control DUT (
        .aclk, .aresetn, .ce, .awvalid, .awready, .awaddr, .awprot, .wvalid,
        .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
        .araddr, .arprot, .rvalid, .rready, .rdata, .rresp, .short_timer_enable,
        .short_timer_toggle, .long_timer_enable, .long_timer_toggle,
        .port3_bit6_port_data, .port3_bit1_pin, .port2_bit0_pin,
        .short_timer_output, .long_timer_output, .port3_bit6_pin, .irq
    );

    ir_link_model far_end (
        .aclk, .aresetn, .fire, .use_alt(alt), .width, .port3_bit1_pin,
        .port2_bit0_pin
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic comb(input logic [1:0] f, input logic s, input logic l);
        case (f)
            2'h0: return s & l;
            2'h1: return s | l;
            2'h2: return ~(s | l);
            default: return ~(s & l);
        endcase
    endfunction

    // Forced submodes override the long timer level
    function automatic logic exp_l(input logic [1:0] sub, input logic v);
        return sub[1] ? sub[0] : v;
    endfunction

    // Flags {rise, fall} left by one low-going pulse for an edge code
    function automatic logic [1:0] exp_flags(input logic [1:0] e);
        return (e == 2'h0) ? 2'h1 : (e == 2'h1) ? 2'h2 : (e == 2'h2) ? 2'h3 : 2'h0;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= {22'h0, idx, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'h0;
            if (wready)
                wvalid <= 1'h0;
        end while (awvalid && !awready || wvalid && !wready);
        do @(posedge aclk); while (bvalid !== 1'h1);
        resp = bresp;
        bready <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] idx);
        @(posedge aclk);
        araddr <= {22'h0, idx, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge aclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge aclk); while (rvalid !== 1'h1);
        rdv = rdata;
        resp = rresp;
        rready <= 1'h0;
    endtask

    // Hang guard sized well above the roughly eight hundred cycles the tests need
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            failures++;
            $display("[FAIL] %0t timeout", $time);
            end_sim();
        end
    end

    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, fire, alt} = 8'h0;
        {short_timer_enable, short_timer_toggle, long_timer_enable} = 3'h0;
        {long_timer_toggle, port3_bit6_port_data} = 2'h0;
        {awaddr, wdata, araddr} = 96'h0;
        {awprot, arprot, width} = 10'h0;
        ce = 1'h1;
        wstrb = 4'hF;
        seed = 32'hD360A498;
        tick(2);
        aresetn <= 1'h1;
        tick(2);
        rd(`CTRL_IDX);
        chk(rdv, 32'h0, "ctrl reset");
        chk({short_timer_output, long_timer_output, port3_bit6_pin, irq}, 4'hC, "idle");
        rd(8'h07);
        chk(resp, `RESP_SLVERR, "unmapped read");
        wr(8'h09, 8'hFF);
        chk(resp, `RESP_SLVERR, "unmapped write");
        // Every combine and submode code, random initial levels and port data
        for (int f = 0; f < 4; f++)
        begin
            seed = lfsr(seed);
            ini = seed[1:0];
            wr(`CTRL_IDX, {2'h1, f[1:0], f[1:0], ini});
            rd(`CTRL_IDX);
            chk(rdv, {24'h0, 2'h1, f[1:0], f[1:0], ini}, "ctrl readback");
            chk(short_timer_output, !ini[1], "short idle");
            chk(long_timer_output, exp_l(f[1:0], ~ini[0]), "long idle");
            short_timer_enable <= 1'h1;
            long_timer_enable <= 1'h1;
            port3_bit6_port_data <= seed[2];
            tick(4);
            chk(short_timer_output, ini[1], "short start");
            el = exp_l(f[1:0], ini[0]);
            chk(long_timer_output, el, "long start");
            chk(port3_bit6_pin, comb(f[1:0], ini[1], el), "pin comb");
            // A toggle pulse while ce is low must leave the frozen outputs alone
            ce <= 1'h0;
            short_timer_toggle <= 1'h1;
            tick(2);
            short_timer_toggle <= 1'h0;
            ce <= 1'h1;
            tick(2);
            chk(short_timer_output, ini[1], "frozen by ce");
            short_timer_toggle <= 1'h1;
            long_timer_toggle <= 1'h1;
            tick(1);
            short_timer_toggle <= 1'h0;
            long_timer_toggle <= 1'h0;
            tick(4);
            el = exp_l(f[1:0], ~ini[0]);
            chk(short_timer_output, !ini[1], "short toggle");
            chk(long_timer_output, el, "long toggle");
            chk(port3_bit6_pin, comb(f[1:0], ~ini[1], el), "pin toggle");
            short_timer_enable <= 1'h0;
            long_timer_enable <= 1'h0;
            wr(`CTRL_IDX, {6'h0, ini});
            tick(4);
            chk(port3_bit6_pin, seed[2], "pin as port");
        end
        // Edge codes, filter lengths and input selection from the case table
        for (int i = 0; i < 10; i++)
        begin
            c = dcase[i];
            seed = lfsr(seed);
            mk = seed[1:0];
            wr(`MASK_IDX, {6'h0, mk});
            wr(`CTRL_IDX, {1'h1, c[9], c[13:12], c[11:10], 2'h3});
            wr(`STATUS_IDX, 8'h03);
            width <= c[3:0];
            alt <= c[8];
            fire <= 1'h1;
            tick(1);
            fire <= 1'h0;
            tick(30);
            ef = c[7] ? exp_flags(c[13:12]) : 2'h0;
            rd(`CTRL_IDX);
            chk(rdv[1:0], ef, "ctrl flags");
            rd(`STATUS_IDX);
            chk(rdv[1:0], ef, "status flags");
            chk(irq, |(ef & mk), "irq level");
            wr(`CTRL_IDX, {1'h1, c[9], c[13:12], c[11:10], 2'h0});
            rd(`CTRL_IDX);
            chk(rdv[1:0], ef, "zero write kept");
            wr(`CTRL_IDX, {1'h1, c[9], c[13:12], c[11:10], 2'h3});
            rd(`CTRL_IDX);
            chk(rdv[1:0], 2'h0, "one write clears");
            wr(`STATUS_IDX, 8'h03);
            tick(2);
            chk(irq, 1'h0, "irq cleared");
        end
        end_sim();
    end
endmodule
